// [logic/dctc_channel.sv]
// Termination control for one general DMA channel
module dctc_channel
  import dctc_pkg::*;
#(
  parameter int unsigned COUNT_WIDTH = 32,
  parameter int unsigned BD_INDEX_WIDTH = 4
)
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic transferEndLineIn,
  output logic transferEndLineOut,
  output logic transferEndLineOe,
  output logic transferAckLine,
  input wire logic busS3Fall,
  input wire logic busS5,
  input wire logic busCycleEnd,
  input wire logic [2:0] opBytes,
  output logic srcCycleReq,
  output logic dstCycleReq,
  input wire logic runSet,
  input wire logic runClear,
  input wire logic chanResetSet,
  input wire logic channelInitCommand,
  input wire logic ackPhaseSelect,
  input wire logic syncRequestBypass,
  input wire logic dualAddress,
  input wire logic peripheralIsSource,
  input wire logic [1:0] baseMode,
  input wire logic [2:0] statusClear,
  input wire logic [2:0] statusMask,
  input wire logic bdLoadValid,
  input wire logic [15:0] bdLoadStatus,
  input wire logic [COUNT_WIDTH-1:0] bdLoadCount,
  input wire logic [COUNT_WIDTH-1:0] bdLoadSrc,
  input wire logic [COUNT_WIDTH-1:0] bdLoadDst,
  output logic bdLoadReq,
  output logic [BD_INDEX_WIDTH-1:0] bdIndex,
  output logic bdWriteBack,
  output logic [15:0] bdStatusOut,
  output logic channelRunBit,
  output logic channelResetBit,
  output logic [2:0] channelStatusReg,
  output logic channelIrq,
  output logic [COUNT_WIDTH-1:0] byteCounter,
  output logic [COUNT_WIDTH-1:0] sourcePointer,
  output logic [COUNT_WIDTH-1:0] destPointer
);
  dctc_sync_if syncBus ();
  dctc_state_type state_r;
  logic endPending_r;
  logic srcEnd_r;
  logic initNeeded_r;
  logic [15:0] bdStat_r;
  logic sampleNow;
  logic endHit;
  logic lastCycle;
  logic srcSideSample;
  logic [COUNT_WIDTH-1:0] step;
  logic [2:0] stEvents;

  assign syncBus.rawEnd = ~transferEndLineIn;
  assign syncBus.bypass = syncRequestBypass;

  dctc_end_sync endSync (
    .ref_clk(ref_clk),
    .srst(srst),
    .port(syncBus.sync)
  );

  // Byte count of one operand, widened to the counter width
  function automatic logic [COUNT_WIDTH-1:0] widen(input logic [2:0] b);
    widen = {{(COUNT_WIDTH-3){1'b0}}, b};
  endfunction
  // Final operand of a count; a zero count wraps the full range, so it is not final
  function automatic logic finalOp(input logic [COUNT_WIDTH-1:0] cnt, input logic [COUNT_WIDTH-1:0] stp);
    finalOp = (cnt != '0) && (cnt <= stp);
  endfunction

  // ==========================================
  // End line sampling
  assign step = widen(opBytes);
  assign srcSideSample = ~ackPhaseSelect;
  // S5 gives a dual-address source peripheral one extra clock
  assign sampleNow = (state_r == DCTC_SRC && srcSideSample && dualAddress && peripheralIsSource)
    ? busS5 : busS3Fall;
  // Strobes repeat each wait state; the last one before cycle end wins
  always_ff @(posedge ref_clk)
  begin
    if (srst || state_r == DCTC_IDLE || busCycleEnd)
      endPending_r <= 1'b0;
    else if (sampleNow)
      endPending_r <= syncBus.endSeen;
  end
  // Our own count-driven end must not read back as a peripheral end; a peripheral
  // end on that same final cycle is therefore taken as a plain count end
  assign endHit = busCycleEnd && (sampleNow ? syncBus.endSeen : endPending_r) &&
    ((state_r == DCTC_SRC) == srcSideSample) && !transferEndLineOe;
  assign lastCycle = finalOp(byteCounter, step) && state_r == DCTC_DST;

  // ==========================================
  // Transfer sequencer
  always_ff @(posedge ref_clk)
  begin
    if (srst || chanResetSet)
      state_r <= DCTC_IDLE;
    else
    begin
      unique case (state_r)
        DCTC_IDLE:
          if (channelRunBit && !initNeeded_r)
            state_r <= (baseMode == DCTC_SINGLE) ? DCTC_SRC : DCTC_RELOAD;
        // Suspension parks here with requests held off, so a resume keeps count and pointers
        DCTC_SRC:
          if (busCycleEnd)
            state_r <= DCTC_DST;
        DCTC_DST:
          if (busCycleEnd)
          begin
            if (endHit || srcEnd_r)
              state_r <= DCTC_STOP;
            else if (lastCycle && (baseMode == DCTC_SINGLE || bdStat_r[DCTC_BD_LAST_BIT] && !bdStat_r[DCTC_BD_CONT_BIT]))
              state_r <= DCTC_STOP;
            else if (lastCycle)
              state_r <= DCTC_RELOAD;
            else
              state_r <= DCTC_SRC;
          end
        DCTC_RELOAD:
          if (bdLoadValid)
            state_r <= bdLoadStatus[DCTC_BD_VALID_BIT] ? DCTC_SRC : DCTC_STOP;
        DCTC_STOP:
          state_r <= DCTC_IDLE;
        default:
          state_r <= DCTC_IDLE;
      endcase
    end
  end

  // ==========================================
  // Source-side end remembered until destination completes
  always_ff @(posedge ref_clk)
  begin
    if (srst || state_r == DCTC_IDLE)
      srcEnd_r <= 1'b0;
    else if (state_r == DCTC_SRC && endHit)
      srcEnd_r <= 1'b1;
  end

  // ==========================================
  // Pointers and counter
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      byteCounter <= DCTC_COUNT_RST;
      sourcePointer <= DCTC_COUNT_RST;
      destPointer <= DCTC_COUNT_RST;
    end
    else if (state_r == DCTC_RELOAD && bdLoadValid)
    begin
      byteCounter <= bdLoadCount;
      sourcePointer <= bdLoadSrc;
      destPointer <= bdLoadDst;
    end
    else if (busCycleEnd && state_r == DCTC_SRC)
      sourcePointer <= sourcePointer + step;
    else if (busCycleEnd && state_r == DCTC_DST)
    begin
      byteCounter <= byteCounter - step;
      destPointer <= destPointer + step;
    end
  end

  // ==========================================
  // Descriptor walk and write-back
  always_ff @(posedge ref_clk)
  begin
    if (srst || channelInitCommand)
      bdIndex <= '0;
    else if (state_r == DCTC_DST && busCycleEnd && lastCycle && !endHit)
      bdIndex <= bdStat_r[DCTC_BD_WRAP_BIT] ? '0 : bdIndex + 1'b1;
  end
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      bdStat_r <= 16'h0;
    else if (state_r == DCTC_RELOAD && bdLoadValid)
      bdStat_r <= bdLoadStatus;
  end
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      bdWriteBack <= 1'b0;
      bdStatusOut <= 16'h0;
    end
    else
    begin
      bdWriteBack <= 1'b0;
      if (state_r == DCTC_DST && busCycleEnd && baseMode != DCTC_SINGLE && (endHit || srcEnd_r))
      begin
        bdWriteBack <= 1'b1;
        // Auto mode: external flag, valid cleared; chain: abort flag, ready cleared
        bdStatusOut <= (bdStat_r & ~(16'h1 << DCTC_BD_VALID_BIT)) | (16'h1 << DCTC_BD_EXTEND_BIT);
      end
      else if (state_r == DCTC_DST && busCycleEnd && lastCycle && baseMode != DCTC_SINGLE)
      begin
        bdWriteBack <= 1'b1;
        bdStatusOut <= bdStat_r & ~(16'h1 << DCTC_BD_VALID_BIT);
      end
    end
  end
  // Registered request, dropped on the answer so one reload asks once
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      bdLoadReq <= 1'b0;
    else
      bdLoadReq <= state_r == DCTC_RELOAD && !bdLoadValid;
  end

  // ==========================================
  // Run and reset bits
  logic chainEnd;
  logic extStop;
  assign extStop = state_r == DCTC_DST && busCycleEnd && (endHit || srcEnd_r);
  // Continuous bit keeps looping; last flag only honoured outside it
  assign chainEnd = state_r == DCTC_DST && busCycleEnd && lastCycle &&
    (baseMode == DCTC_SINGLE || (bdStat_r[DCTC_BD_LAST_BIT] && !bdStat_r[DCTC_BD_CONT_BIT]));
  always_ff @(posedge ref_clk)
  begin
    if (srst || chanResetSet)
      channelRunBit <= 1'b0;
    else if (runSet)
      channelRunBit <= 1'b1;
    else if (runClear || extStop || chainEnd || state_r == DCTC_RELOAD && bdLoadValid &&
             !bdLoadStatus[DCTC_BD_VALID_BIT])
      channelRunBit <= 1'b0;
  end
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      channelResetBit <= 1'b0;
    else if (chanResetSet || extStop && baseMode == DCTC_CHAIN)
      channelResetBit <= 1'b1;
    else if (runSet)
      channelResetBit <= 1'b0;
  end
  // Descriptor modes need the init command after a channel reset or a chain-mode external end, not after srst
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      initNeeded_r <= 1'b0;
    else if (channelInitCommand)
      initNeeded_r <= 1'b0;
    else if ((chanResetSet || extStop && baseMode == DCTC_CHAIN) && baseMode != DCTC_SINGLE)
      initNeeded_r <= 1'b1;
  end

  // ==========================================
  // Status: hardware set wins over write-one-to-clear
  assign stEvents[DCTC_ST_DONE_BIT] = extStop || chainEnd;
  assign stEvents[DCTC_ST_BUFCMP_BIT] = state_r == DCTC_DST && busCycleEnd && lastCycle &&
    baseMode != DCTC_SINGLE && bdStat_r[DCTC_BD_INTREQ_BIT];
  assign stEvents[DCTC_ST_OOB_BIT] = state_r == DCTC_RELOAD && bdLoadValid &&
    !bdLoadStatus[DCTC_BD_VALID_BIT];
  always_ff @(posedge ref_clk)
  begin
    if (srst || chanResetSet)
      channelStatusReg <= DCTC_STATUS_RST;
    else
      channelStatusReg <= (channelStatusReg & ~statusClear) | stEvents;
  end
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      channelIrq <= 1'b0;
    else
      channelIrq <= |(((channelStatusReg & ~statusClear) | stEvents) & statusMask);
  end

  // ==========================================
  // Bus requests and handshake outputs
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      srcCycleReq <= 1'b0;
      dstCycleReq <= 1'b0;
      transferAckLine <= 1'b0;
      transferEndLineOut <= 1'b1;
      transferEndLineOe <= 1'b0;
    end
    else
    begin
      srcCycleReq <= state_r == DCTC_SRC && channelRunBit;
      dstCycleReq <= state_r == DCTC_DST;
      transferAckLine <= (state_r == DCTC_SRC) == srcSideSample && (state_r == DCTC_SRC || state_r == DCTC_DST);
      // Count-driven end on the last destination cycle, only when the destination side is acknowledged, active low
      transferEndLineOe <= finalOp(byteCounter, step) && state_r == DCTC_DST && !srcSideSample;
      transferEndLineOut <= 1'b0;
    end
  end
endmodule

// [logic/dctc_end_sync.sv]
// Two-stage synchroniser for the end-of-transfer line with bypass
module dctc_end_sync
  import dctc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  dctc_sync_if.sync port
);
  logic meta_r;
  logic stable_r;
  // ==========================================
  // Synchroniser chain, first stage read only by second
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      meta_r <= 1'b0;
      stable_r <= 1'b0;
    end
    else
    begin
      meta_r <= port.rawEnd;
      stable_r <= meta_r;
    end
  end
  // Bypass costs setup margin but saves two clocks of latency
  assign port.endSeen = port.bypass ? port.rawEnd : stable_r;
endmodule

// [logic/dctc_pkg.sv]
// Shared constants and types of the DMA channel termination control block
package dctc_pkg;
  // Descriptor status field positions
  localparam int unsigned DCTC_BD_VALID_BIT = 15;
  localparam int unsigned DCTC_BD_WRAP_BIT = 13;
  localparam int unsigned DCTC_BD_INTREQ_BIT = 12;
  localparam int unsigned DCTC_BD_LAST_BIT = 11;
  localparam int unsigned DCTC_BD_CONT_BIT = 9;
  localparam int unsigned DCTC_BD_EXTEND_BIT = 1;
  // Status bit positions
  localparam int unsigned DCTC_ST_DONE_BIT = 0;
  localparam int unsigned DCTC_ST_BUFCMP_BIT = 1;
  localparam int unsigned DCTC_ST_OOB_BIT = 2;
  localparam int unsigned DCTC_ST_WIDTH = 3;
  // Reset values
  localparam logic [2:0] DCTC_STATUS_RST = 3'h0;
  localparam logic [31:0] DCTC_COUNT_RST = 32'h0;
  // Buffer mode of the channel
  typedef enum logic [1:0] {DCTC_SINGLE, DCTC_AUTO, DCTC_CHAIN} dctc_mode_type;
  // Transfer sequencer states
  typedef enum logic [2:0] {DCTC_IDLE, DCTC_SRC, DCTC_DST, DCTC_RELOAD, DCTC_STOP} dctc_state_type;
endpackage

// [logic/dctc_sync_if.sv]
// Interface carrying the raw and synchronised end-of-transfer line
interface dctc_sync_if;
  logic rawEnd;
  logic bypass;
  logic endSeen;
  modport owner (output rawEnd, output bypass, input endSeen);
  modport sync (input rawEnd, input bypass, output endSeen);
endinterface

// [test/dctc_chk.sv]
// Port assertions for the DMA channel termination control block
module dctc_chk
  import dctc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic transferEndLineIn,
  input wire logic transferEndLineOut,
  input wire logic transferEndLineOe,
  input wire logic busS3Fall,
  input wire logic busCycleEnd,
  input wire logic srcCycleReq,
  input wire logic dstCycleReq,
  input wire logic ackPhaseSelect,
  input wire logic syncRequestBypass,
  input wire logic [1:0] baseMode,
  input wire logic [2:0] statusMask,
  input wire logic bdWriteBack,
  input wire logic [15:0] bdStatusOut,
  input wire logic channelRunBit,
  input wire logic channelResetBit,
  input wire logic [2:0] channelStatusReg,
  input wire logic channelIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Clocking and steps of a destination end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence dstEndSeen;
    dstCycleReq && ackPhaseSelect && syncRequestBypass && busS3Fall && !transferEndLineIn && !transferEndLineOe;
  endsequence
  sequence cycleCloses;
    ##[0:3] busCycleEnd;
  endsequence
  // ==========================================
  // Properties
  oe_low_drive_a: assert property (transferEndLineOe |-> !transferEndLineOut)
    else $error("end line driven high");
  req_exclusive_a: assert property (!(srcCycleReq && dstCycleReq))
    else $error("source and destination at once");
  dst_end_stop_a: assert property (dstEndSeen ##0 cycleCloses |-> ##2 (!srcCycleReq && !dstCycleReq)[*4])
    else $error("cycles after destination end");
  done_clears_run_a: assert property ($rose(channelStatusReg[0]) |-> ##[0:1] !channelRunBit)
    else $error("run bit kept after done");
  oob_stops_run_a: assert property ($rose(channelStatusReg[2]) |-> ##[0:1] !channelRunBit)
    else $error("run bit kept after out of buffers");
  auto_close_a: assert property (bdWriteBack && baseMode == 2'h1 && bdStatusOut[1] |-> !bdStatusOut[15])
    else $error("closed descriptor still valid");
  chain_abort_a: assert property (bdWriteBack && baseMode == 2'h2 && bdStatusOut[1] |-> ##[0:2] channelResetBit)
    else $error("channel reset not set on abort");
  irq_masked_a: assert property (channelIrq |->
    |((channelStatusReg | $past(channelStatusReg)) & (statusMask | $past(statusMask))))
    else $error("interrupt without masked status");
endmodule

bind dctc_channel dctc_chk chk (.ref_clk, .srst, .transferEndLineIn, .transferEndLineOut, .transferEndLineOe,
  .busS3Fall, .busCycleEnd, .srcCycleReq, .dstCycleReq, .ackPhaseSelect, .syncRequestBypass, .baseMode,
  .statusMask, .bdWriteBack, .bdStatusOut, .channelRunBit, .channelResetBit, .channelStatusReg, .channelIrq);

// [test/dctc_periph.sv]
// Far-side model: bus cycle strobes, peripheral end line and descriptor answers
module dctc_periph
  import dctc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic srcCycleReq,
  input wire logic dstCycleReq,
  input wire logic ackPhaseSelect,
  input wire logic armEnd,
  input wire logic bdLoadReq,
  input wire logic [15:0] bdStat,
  output logic busS3Fall,
  output logic busS5,
  output logic busCycleEnd,
  output logic endLow,
  output logic bdLoadValid,
  output logic [15:0] bdLoadStatus,
  output logic [31:0] bdLoadCount,
  output logic [31:0] bdLoadSrc,
  output logic [31:0] bdLoadDst
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt;
  logic served;
  // Bus cycle count; a gap after the end so a held request cannot retrigger
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      cnt <= 3'h0;
    else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
    else if (srcCycleReq || dstCycleReq)
      cnt <= 3'h5;
  end
  assign busS3Fall = (cnt == 3'h3);
  assign busS5 = (cnt == 3'h2);
  assign busCycleEnd = (cnt == 3'h2);
  // End driven two clocks before S3, so ahead of acknowledge and synchroniser
  assign endLow = armEnd && (cnt >= 3'h3) && (ackPhaseSelect ? dstCycleReq : srcCycleReq);
  // One answer per request; data inverted while not valid
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      bdLoadValid <= 1'b0;
      served <= 1'b0;
    end
    else
    begin
      bdLoadValid <= bdLoadReq && !served && !bdLoadValid;
      served <= bdLoadReq && (served || bdLoadValid);
    end
  end
  assign bdLoadStatus = bdLoadValid ? bdStat : ~bdStat;
  assign bdLoadCount = bdLoadValid ? 32'h10 : 32'hffffffef;
  assign bdLoadSrc = bdLoadValid ? 32'h100 : 32'hfffffeff;
  assign bdLoadDst = bdLoadValid ? 32'h1100 : 32'hffffeeff;
endmodule

// [test/tb_top.sv]
// Self-checking bench of the termination control block
module tb_top
  import dctc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic runSet = 1'b0;
  logic runClear = 1'b0;
  logic channelInitCommand = 1'b0;
  logic ackPhaseSelect = 1'b1;
  logic syncRequestBypass = 1'b1;
  logic armEnd = 1'b0;
  logic [1:0] baseMode = 2'h0;
  logic [2:0] statusClear = 3'h0;
  logic [2:0] statusMask = 3'h1;
  logic [15:0] bdStat = 16'h0;
  logic transferEndLineOut, transferEndLineOe, transferAckLine, busS3Fall, busS5, busCycleEnd, endLow;
  logic srcCycleReq, dstCycleReq, bdLoadReq, bdLoadValid, bdWriteBack, channelRunBit, channelResetBit, channelIrq;
  logic [15:0] bdLoadStatus, bdStatusOut;
  logic [31:0] bdLoadCount, bdLoadSrc, bdLoadDst, byteCounter, sourcePointer, destPointer;
  logic [3:0] bdIndex;
  logic [2:0] channelStatusReg;
  // Pulled-up line: low when either party pulls it
  wire transferEndLineIn = endLow ? 1'b0 : (transferEndLineOe ? transferEndLineOut : 1'b1);
  int n_fail = 0;
  int num_checks = 0;
  always #4 ref_clk = ~ref_clk;
  // ==========================================
  // Block and far side
  dctc_channel dut (.ref_clk, .srst, .transferEndLineIn, .transferEndLineOut, .transferEndLineOe, .transferAckLine,
    .busS3Fall, .busS5, .busCycleEnd, .opBytes(3'h4), .srcCycleReq, .dstCycleReq, .runSet, .runClear,
    .chanResetSet(1'b0), .channelInitCommand, .ackPhaseSelect, .syncRequestBypass, .dualAddress(1'b0),
    .peripheralIsSource(1'b0), .baseMode, .statusClear, .statusMask, .bdLoadValid, .bdLoadStatus, .bdLoadCount,
    .bdLoadSrc, .bdLoadDst, .bdLoadReq, .bdIndex, .bdWriteBack, .bdStatusOut, .channelRunBit, .channelResetBit,
    .channelStatusReg, .channelIrq, .byteCounter, .sourcePointer, .destPointer);
  dctc_periph peer (.ref_clk, .srst, .srcCycleReq, .dstCycleReq, .ackPhaseSelect, .armEnd, .bdLoadReq, .bdStat,
    .busS3Fall, .busS5, .busCycleEnd, .endLow, .bdLoadValid, .bdLoadStatus, .bdLoadCount, .bdLoadSrc, .bdLoadDst);
  // ==========================================
  // Helpers
  task automatic check(input logic ok, input string what);
    num_checks++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  // Reset held four cycles, init only where a descriptor mode needs it
  task automatic start(input logic [1:0] m, input logic [15:0] st);
    srst = 1'b1;
    baseMode = m;
    bdStat = st;
    repeat (4) @(negedge ref_clk);
    srst = 1'b0;
    @(negedge ref_clk);
    channelInitCommand = (m != 2'h0);
    @(negedge ref_clk);
    channelInitCommand = 1'b0;
    runSet = 1'b1;
    @(negedge ref_clk);
    runSet = 1'b0;
  endtask
  task automatic wait_st(input int b);
    for (int i = 0; i < 800 && channelStatusReg[b] !== 1'b1; i++) @(negedge ref_clk);
  endtask
  task automatic wait_wb;
    for (int i = 0; i < 800 && bdWriteBack !== 1'b1; i++) @(negedge ref_clk);
  endtask
  // ==========================================
  // Scenarios
  task automatic test_reset;
    repeat (4) @(negedge ref_clk);
    check(transferEndLineOut === 1'b1 && transferEndLineOe === 1'b0, "end line reset");
    check(channelRunBit === 1'b0 && channelStatusReg === DCTC_STATUS_RST, "status reset");
    $display("test_reset done");
  endtask
  task automatic test_single_end;
    armEnd = 1'b1;
    start(2'h0, 16'h0);
    wait_st(DCTC_ST_DONE_BIT);
    armEnd = 1'b0;
    check(channelStatusReg[DCTC_ST_DONE_BIT] === 1'b1, "no done");
    check(channelRunBit === 1'b0, "run kept");
    check(byteCounter !== DCTC_COUNT_RST, "count kept");
    statusClear = 3'h1;
    @(negedge ref_clk);
    statusClear = 3'h0;
    repeat (2) @(negedge ref_clk);
    check(channelStatusReg[DCTC_ST_DONE_BIT] === 1'b0 && channelIrq === 1'b0, "done not cleared");
    $display("test_single_end done");
  endtask
  task automatic test_reload;
    start(2'h1, 16'h8200);
    for (int i = 0; i < 800 && transferEndLineOe !== 1'b1; i++) @(negedge ref_clk);
    check(transferEndLineIn === 1'b0 && transferAckLine === 1'b1, "own end drive");
    for (int i = 0; i < 800 && bdIndex === 4'h0; i++) @(negedge ref_clk);
    check(bdIndex === 4'h1 && channelRunBit === 1'b1, "no reload");
    check(byteCounter === 32'h0 && sourcePointer === 32'h110 && destPointer === 32'h1110, "pointers");
    $display("test_reload done");
  endtask
  task automatic test_auto_end;
    armEnd = 1'b1;
    start(2'h1, 16'h8200);
    wait_wb;
    check(bdStatusOut[DCTC_BD_EXTEND_BIT] === 1'b1 && bdStatusOut[DCTC_BD_VALID_BIT] === 1'b0, "auto close");
    wait_st(DCTC_ST_DONE_BIT);
    armEnd = 1'b0;
    check(channelRunBit === 1'b0, "auto run kept");
    $display("test_auto_end done");
  endtask
  task automatic test_chain_end;
    armEnd = 1'b1;
    start(2'h2, 16'h8000);
    wait_wb;
    check(bdStatusOut[DCTC_BD_EXTEND_BIT] === 1'b1 && bdStatusOut[DCTC_BD_VALID_BIT] === 1'b0, "abort");
    wait_st(DCTC_ST_DONE_BIT);
    armEnd = 1'b0;
    repeat (2) @(negedge ref_clk);
    check(channelResetBit === 1'b1 && channelRunBit === 1'b0, "chain reset");
    $display("test_chain_end done");
  endtask
  task automatic test_out_of_buffers;
    start(2'h1, 16'h0200);
    wait_st(DCTC_ST_OOB_BIT);
    check(channelStatusReg[DCTC_ST_OOB_BIT] === 1'b1 && channelRunBit === 1'b0, "no oob stop");
    $display("test_out_of_buffers done");
  endtask
  // Source-side end through the synchroniser: the pending destination access still runs
  task automatic test_src_end;
    ackPhaseSelect = 1'b0;
    syncRequestBypass = 1'b0;
    armEnd = 1'b1;
    start(2'h0, 16'h0);
    wait_st(DCTC_ST_DONE_BIT);
    armEnd = 1'b0;
    check(channelRunBit === 1'b0 && destPointer === 32'h4 && sourcePointer === 32'h4, "source end");
    check(byteCounter === 32'hfffffffc, "source end count");
    ackPhaseSelect = 1'b1;
    syncRequestBypass = 1'b1;
    $display("test_src_end done");
  endtask
  // Run bit cleared mid-descriptor, then set again: no reload, transfer picks up
  task automatic test_suspend;
    logic [31:0] held;
    start(2'h1, 16'h8200);
    for (int i = 0; i < 800 && sourcePointer !== 32'h104; i++) @(negedge ref_clk);
    runClear = 1'b1;
    @(negedge ref_clk);
    runClear = 1'b0;
    repeat (20) @(negedge ref_clk);
    held = byteCounter;
    check(channelRunBit === 1'b0 && sourcePointer === 32'h104 && held === 32'hc, "suspend");
    runSet = 1'b1;
    @(negedge ref_clk);
    runSet = 1'b0;
    for (int i = 0; i < 200 && byteCounter === held; i++) @(negedge ref_clk);
    check(byteCounter === 32'h8 && sourcePointer === 32'h108 && channelRunBit === 1'b1, "resume");
    $display("test_suspend done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Watchdog sized well beyond eight scenarios of a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    report_and_stop();
  end
  initial
  begin
    test_reset();
    test_single_end();
    test_reload();
    test_auto_end();
    test_chain_end();
    test_out_of_buffers();
    test_src_end();
    test_suspend();
    report_and_stop();
  end
endmodule
